//--- rtl/snmc_decoder.sv
// Purpose: collect link bits into a message and extract its fields
// Assumes: sender keeps field layout; one clock, synchronous reset
// Notes: a two-entry buffer holds decoded messages against a stalling consumer
`timescale 1ns/1ps
`include "snmc_defines.svh"
module snmc_decoder #(
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // link side
   snmc_link_if.rx link,
   // management side
   output logic msgValid,
   input wire logic msgReady,
   output snmc_pkg::snmc_msg_type msgData,
   output logic badPulse
);
   import snmc_pkg::*;

   // ****************************************
   // bit shifter
   // ****************************************
   logic [`SNMC_MSG_W-1:0] shift_reg, shift_next;
   logic [6:0] count_reg, count_next;
   logic [1:0] fill_reg;
   logic [0:0] wrPtr_reg, rdPtr_reg;
   snmc_msg_type store_reg [DEPTH];
   logic badPulse_reg;

   wire logic bufFull = (fill_reg == 2'(DEPTH));
   // a full buffer stalls the link so no message is lost
   assign link.bitReady = !bufFull;
   wire logic bitTake = link.bitValid && link.bitReady;
   wire logic [6:0] countInc = 7'(count_reg + 7'h01);
   // lsb-first fields: each new bit lands at its position
   always_comb begin
      shift_next = shift_reg;
      shift_next[count_reg[5:0]] = link.bitData;
   end
   assign count_next = (bitTake && link.bitLast) ? 7'h00 : (bitTake ? countInc : count_reg);
   wire logic msgDone = bitTake && link.bitLast;

   // ****************************************
   // field extraction
   // ****************************************
   wire logic [3:0] h0 = shift_next[`SNMC_H0_LSB +: 4];
   wire logic [3:0] h1 = shift_next[`SNMC_H1_LSB +: 4];
   wire logic [1:0] spr2 = shift_next[`SNMC_SPR2_LSB +: 2];
   wire logic [3:0] spr4 = shift_next[`SNMC_SPR4_LSB +: 4];
   wire logic [3:0] dlSpr = shift_next[`SNMC_DLSPR_LSB +: 4];
   wire logic [3:0] upId = shift_next[`SNMC_UPID_LSB +: 4];
   wire logic lenShort = (countInc == `SNMC_LEN_SHORT);
   wire logic lenDest = (countInc == `SNMC_LEN_DEST);
   wire logic lenUpu = (countInc == `SNMC_LEN_UPU);
   wire logic upKnown = (upId == `SNMC_UP_CONN) || (upId == `SNMC_UP_TEL) || (upId == `SNMC_UP_ISDN)
      || (upId == `SNMC_UP_DATA) || (upId == `SNMC_UP_TEST);
   wire logic isTfr = (h0 == `SNMC_H0_TFM) && (h1 == `SNMC_H1_TFR) && lenDest && (spr2 == 2'h0);
   wire logic isRst = (h0 == `SNMC_H0_RSM) && (h1 == `SNMC_H1_RST) && lenDest && (spr2 == 2'h0);
   wire logic isRsr = (h0 == `SNMC_H0_RSM) && (h1 == `SNMC_H1_RSR) && lenDest && (spr2 == 2'h0);
   wire logic isMim = (h0 == `SNMC_H0_MIM) && (h1 >= `SNMC_H1_MIM_FIRST) && (h1 <= `SNMC_H1_MIM_LAST)
      && lenShort;
   wire logic isTra = (h0 == `SNMC_H0_TRM) && (h1 == `SNMC_H1_TRA) && lenShort;
   wire logic isDlc = (h0 == `SNMC_H0_DLM) && (h1 == `SNMC_H1_DLC) && lenDest && (dlSpr == 4'h0);
   wire logic isDla = (h0 == `SNMC_H0_DLM) && (h1 >= `SNMC_H1_CSS) && (h1 <= `SNMC_H1_CNP) && lenShort;
   wire logic isTfc = (h0 == `SNMC_H0_FLOW) && (h1 == `SNMC_H1_TFC) && lenDest;
   wire logic isRct = (h0 == `SNMC_H0_FLOW) && (h1 == `SNMC_H1_RCT) && lenShort;
   wire logic isUpu = (h0 == `SNMC_H0_UFC) && (h1 == `SNMC_H1_UPU) && lenUpu && (spr2 == 2'h0)
      && (spr4 == 4'h0) && upKnown;

   // first heading code picks the group, the second the message
   snmc_kind_type kind;
   always_comb begin
      kind = SNMC_K_BAD;
      case (h0)
         `SNMC_H0_TFM: begin
            if (isTfr) begin
               kind = SNMC_K_TFR;
            end
         end
         `SNMC_H0_RSM: begin
            if (isRst) begin
               kind = SNMC_K_RST;
            end else if (isRsr) begin
               kind = SNMC_K_RSR;
            end
         end
         `SNMC_H0_MIM: begin
            if (isMim) begin
               kind = SNMC_K_MIM;
            end
         end
         `SNMC_H0_TRM: begin
            if (isTra) begin
               kind = SNMC_K_TRA;
            end
         end
         `SNMC_H0_DLM: begin
            if (isDlc) begin
               kind = SNMC_K_DLC;
            end else if (isDla) begin
               kind = SNMC_K_DLA;
            end
         end
         `SNMC_H0_FLOW: begin
            if (isTfc) begin
               kind = SNMC_K_TFC;
            end else if (isRct) begin
               kind = SNMC_K_RCT;
            end
         end
         `SNMC_H0_UFC: begin
            if (isUpu) begin
               kind = SNMC_K_UPU;
            end
         end
         // spare groups and those handled elsewhere are all rejected
         default: begin
            kind = SNMC_K_BAD;
         end
      endcase
   end

   snmc_msg_type decoded;
   always_comb begin
      decoded.kind = kind;
      decoded.h1 = h1;
      decoded.dpc = shift_next[13:0];
      decoded.opc = shift_next[27:14];
      decoded.slc = shift_next[`SNMC_SLC_LSB +: 4];
      decoded.dest = shift_next[`SNMC_DEST_LSB +: 14];
      decoded.cong = (kind == SNMC_K_TFC) ? spr2 : 2'h0;
      decoded.linkId = shift_next[`SNMC_DLID_LSB +: 12];
      decoded.userPart = upId;
   end

   // ****************************************
   // two-entry output buffer
   // ****************************************
   wire logic msgGood = msgDone && (kind != SNMC_K_BAD);
   wire logic popNow = msgValid && msgReady;
   assign msgValid = (fill_reg != 2'h0);
   assign msgData = store_reg[rdPtr_reg];
   assign badPulse = badPulse_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_reg <= '0;
         count_reg <= 7'h00;
      end else begin
         shift_reg <= msgDone ? '0 : (bitTake ? shift_next : shift_reg);
         count_reg <= count_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         badPulse_reg <= 1'h0;
      end else begin
         badPulse_reg <= msgDone && !msgGood;
      end
   end

   // buffer words carry no reset; msgValid guards them
   always_ff @(posedge clk) begin
      if (msgGood) begin
         store_reg[wrPtr_reg] <= decoded;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fill_reg <= 2'h0;
         wrPtr_reg <= 1'h0;
         rdPtr_reg <= 1'h0;
      end else begin
         if (msgGood) begin
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (popNow) begin
            rdPtr_reg <= ~rdPtr_reg;
         end
         fill_reg <= 2'(fill_reg + {1'h0, msgGood} - {1'h0, popNow});
      end
   end
endmodule : snmc_decoder

//--- rtl/snmc_defines.svh
// Purpose: constants for the network-management message codec
// Assumes: field positions are bit offsets into the packed message word
// Notes: bit 0 of the message word is the first bit on the wire
`ifndef SNMC_DEFINES_SVH
`define SNMC_DEFINES_SVH

// ****************************************
// field positions inside the message word
// ****************************************
`define SNMC_MSG_W 64
`define SNMC_LBL_LSB 0
`define SNMC_H0_LSB 32
`define SNMC_H1_LSB 36
`define SNMC_DEST_LSB 40
`define SNMC_SPR2_LSB 54
`define SNMC_UPID_LSB 56
`define SNMC_SPR4_LSB 60
`define SNMC_DLID_LSB 40
`define SNMC_DLSPR_LSB 52
`define SNMC_SLC_LSB 28

// ****************************************
// lengths in bits of each format
// ****************************************
`define SNMC_LEN_SHORT 7'h28
`define SNMC_LEN_DEST 7'h38
`define SNMC_LEN_UPU 7'h40

// ****************************************
// first heading codes
// ****************************************
`define SNMC_H0_FLOW 4'h3
`define SNMC_H0_TFM 4'h4
`define SNMC_H0_RSM 4'h5
`define SNMC_H0_MIM 4'h6
`define SNMC_H0_TRM 4'h7
`define SNMC_H0_DLM 4'h8
`define SNMC_H0_UFC 4'ha

// ****************************************
// second heading codes
// ****************************************
`define SNMC_H1_RCT 4'h1
`define SNMC_H1_TFC 4'h2
`define SNMC_H1_TFR 4'h3
`define SNMC_H1_RST 4'h1
`define SNMC_H1_RSR 4'h2
`define SNMC_H1_MIM_FIRST 4'h1
`define SNMC_H1_MIM_LAST 4'h8
`define SNMC_H1_TRA 4'h1
`define SNMC_H1_DLC 4'h1
`define SNMC_H1_CSS 4'h2
`define SNMC_H1_CNS 4'h3
`define SNMC_H1_CNP 4'h4
`define SNMC_H1_UPU 4'h1

// ****************************************
// user part identities
// ****************************************
`define SNMC_UP_CONN 4'h3
`define SNMC_UP_TEL 4'h4
`define SNMC_UP_ISDN 4'h5
`define SNMC_UP_DATA 4'h6
`define SNMC_UP_TEST 4'h8

`endif

//--- rtl/snmc_pkg.sv
// Purpose: types shared by both ends of the codec
// Assumes: nothing beyond the defines header
// Notes: message kinds are abstract; codes come from the defines
package snmc_pkg;
   typedef enum logic [3:0] {
      SNMC_K_TFR, SNMC_K_RST, SNMC_K_RSR, SNMC_K_MIM, SNMC_K_TRA, SNMC_K_DLC,
      SNMC_K_DLA, SNMC_K_TFC, SNMC_K_RCT, SNMC_K_UPU, SNMC_K_BAD
   } snmc_kind_type;

   typedef struct packed {
      snmc_kind_type kind;
      logic [3:0] h1;
      logic [13:0] dpc;
      logic [13:0] opc;
      logic [3:0] slc;
      logic [13:0] dest;
      logic [1:0] cong;
      logic [11:0] linkId;
      logic [3:0] userPart;
   } snmc_msg_type;
endpackage : snmc_pkg

//--- rtl/snmc_link_if.sv
// Purpose: serial link between the codec ends
// Assumes: one clock shared by both ends
// Notes: one bit per valid/ready beat, lsb of each field first
`timescale 1ns/1ps
interface snmc_link_if (
   input wire logic clk
);
   logic bitValid;
   logic bitData;
   logic bitLast;
   logic bitReady;

   modport tx (
      output bitValid,
      output bitData,
      output bitLast,
      input bitReady
   );
   modport rx (
      input bitValid,
      input bitData,
      input bitLast,
      output bitReady
   );
endinterface : snmc_link_if

//--- rtl/snmc_encoder.sv
// Purpose: build a management message and send it bit by bit
// Assumes: requester gives a recognised kind; one clock, sync reset
// Notes: two-entry buffer between request and serialiser
`timescale 1ns/1ps
`include "snmc_defines.svh"
module snmc_encoder (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // management side
   input wire logic reqValid,
   output logic reqReady,
   input snmc_pkg::snmc_msg_type reqData,
   // link side
   snmc_link_if.tx link
);
   import snmc_pkg::*;

   // ****************************************
   // format builder
   // ****************************************
   logic [3:0] h0;
   logic [3:0] h1;
   logic [6:0] len;
   logic [23:0] tail;
   always_comb begin
      h0 = `SNMC_H0_MIM;
      h1 = reqData.h1;
      len = `SNMC_LEN_SHORT;
      tail = {8'h00, 2'h0, reqData.dest}; // spares zero
      case (reqData.kind)
         SNMC_K_TFR: begin h0 = `SNMC_H0_TFM; h1 = `SNMC_H1_TFR; len = `SNMC_LEN_DEST; end
         SNMC_K_RST: begin h0 = `SNMC_H0_RSM; h1 = `SNMC_H1_RST; len = `SNMC_LEN_DEST; end
         SNMC_K_RSR: begin h0 = `SNMC_H0_RSM; h1 = `SNMC_H1_RSR; len = `SNMC_LEN_DEST; end
         SNMC_K_MIM: begin h0 = `SNMC_H0_MIM; end
         SNMC_K_TRA: begin h0 = `SNMC_H0_TRM; h1 = `SNMC_H1_TRA; end
         SNMC_K_DLC: begin
            h0 = `SNMC_H0_DLM;
            h1 = `SNMC_H1_DLC;
            len = `SNMC_LEN_DEST;
            tail = {8'h00, 4'h0, reqData.linkId};
         end
         SNMC_K_DLA: begin h0 = `SNMC_H0_DLM; end
         SNMC_K_TFC: begin
            h0 = `SNMC_H0_FLOW;
            h1 = `SNMC_H1_TFC;
            len = `SNMC_LEN_DEST;
            tail = {8'h00, reqData.cong, reqData.dest};
         end
         SNMC_K_RCT: begin h0 = `SNMC_H0_FLOW; h1 = `SNMC_H1_RCT; end
         SNMC_K_UPU: begin
            h0 = `SNMC_H0_UFC;
            h1 = `SNMC_H1_UPU;
            len = `SNMC_LEN_UPU;
            tail = {4'h0, reqData.userPart, 2'h0, reqData.dest};
         end
         default: begin end
      endcase
   end
   // label sits first on the wire
   wire logic [`SNMC_MSG_W-1:0] built = {tail, h1, h0, reqData.slc, reqData.opc, reqData.dpc};

   // ****************************************
   // two-entry buffer
   // ****************************************
   logic [`SNMC_MSG_W-1:0] bufWord_reg [2];
   logic [6:0] bufLen_reg [2];
   logic [1:0] fill_reg;
   logic wrPtr_reg, rdPtr_reg;
   logic [6:0] pos_reg;
   // unknown kinds are dropped rather than sent half-coded
   wire logic reqOk = (reqData.kind != SNMC_K_BAD);
   assign reqReady = (fill_reg != 2'h2);
   wire logic push = reqValid && reqReady && reqOk;
   wire logic [6:0] curLen = bufLen_reg[rdPtr_reg];
   wire logic lastBit = (pos_reg == 7'(curLen - 7'h01));
   wire logic bitSent = link.bitValid && link.bitReady;
   wire logic pop = bitSent && lastBit;

   // lsb of each field first, starting at the label
   assign link.bitValid = (fill_reg != 2'h0);
   assign link.bitData = bufWord_reg[rdPtr_reg][pos_reg[5:0]];
   // length words carry no reset, so keep the flag quiet while idle
   assign link.bitLast = lastBit && link.bitValid;

   always_ff @(posedge clk) begin
      if (rst) begin
         fill_reg <= 2'h0;
         wrPtr_reg <= 1'h0;
         rdPtr_reg <= 1'h0;
         pos_reg <= 7'h00;
      end else begin
         if (push) begin
            bufWord_reg[wrPtr_reg] <= built;
            bufLen_reg[wrPtr_reg] <= len;
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (pop) begin
            rdPtr_reg <= ~rdPtr_reg;
         end
         pos_reg <= pop ? 7'h00 : (bitSent ? 7'(pos_reg + 7'h01) : pos_reg);
         fill_reg <= 2'(fill_reg + {1'h0, push} - {1'h0, pop});
      end
   end
endmodule : snmc_encoder

//--- dv/snmc_link_properties.sv
// Purpose: wire-level checks on the serial link between the codec ends
// Assumes: signals of the link interface plus the shared clock and reset
// Notes: bits are collected by position so each frame is judged at its last beat
`timescale 1ns/1ps
module snmc_link_properties (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // link
   input wire logic bitValid,
   input wire logic bitData,
   input wire logic bitLast,
   input wire logic bitReady
);
   logic [6:0] beatCnt_reg;
   logic [63:0] bitsSeen_reg;
   wire beat = bitValid && bitReady;
   wire endBeat = beat && bitLast;
   // the final bit is not yet stored, so merge it in
   wire [63:0] curWord = (bitsSeen_reg & ~(64'h1 << beatCnt_reg[5:0])) | (64'(bitData) << beatCnt_reg[5:0]);
   wire [3:0] headZero = curWord[35:32];
   wire [3:0] headOne = curWord[39:36];
   wire shortEnd = endBeat && beatCnt_reg == 7'h27;
   wire destEnd = endBeat && beatCnt_reg == 7'h37;
   wire upuEnd = endBeat && beatCnt_reg == 7'h3f;

   always_ff @(posedge clk) begin
      if (rst) beatCnt_reg <= 7'h00;
      else if (beat) beatCnt_reg <= bitLast ? 7'h00 : beatCnt_reg + 7'h01;
   end
   always_ff @(posedge clk) begin
      if (beat) bitsSeen_reg[beatCnt_reg[5:0]] <= bitData;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ****************************************
   // assertions
   // ****************************************
   a_idle_after_reset: assert property (disable iff (1'b0) rst |=> !bitValid && bitReady)
      else $error("link not idle after reset");
   a_last_with_valid: assert property (bitLast |-> bitValid)
      else $error("last flag without valid");
   a_stalled_bit_held: assert property (bitValid && !bitReady |=>
      bitValid && $stable(bitData) && $stable(bitLast))
      else $error("bit changed while stalled");
   a_frame_length: assert property (endBeat |-> beatCnt_reg inside {7'h27, 7'h37, 7'h3f})
      else $error("frame length not a known format");
   a_head_len: assert property (endBeat |->
      (shortEnd && headZero inside {4'h3, 4'h6, 4'h7, 4'h8})
      || (destEnd && headZero inside {4'h3, 4'h4, 4'h5, 4'h8}) || (upuEnd && headZero == 4'ha))
      else $error("first heading code does not fit length");
   a_code_pairs: assert property (endBeat |->
      (headZero == 4'h6 -> headOne inside {[4'h1:4'h8]})
      && (headZero == 4'h7 -> headOne == 4'h1) && (headZero == 4'h4 -> headOne == 4'h3)
      && (headZero == 4'h5 -> headOne inside {4'h1, 4'h2}) && (shortEnd && headZero == 4'h3 -> headOne == 4'h1)
      && (destEnd && headZero == 4'h3 -> headOne == 4'h2) && (destEnd && headZero == 4'h8 -> headOne == 4'h1)
      && (shortEnd && headZero == 4'h8 -> headOne inside {4'h2, 4'h3, 4'h4}))
      else $error("second heading code not allocated");
   a_dest_spare: assert property (destEnd && headZero inside {4'h4, 4'h5} |-> curWord[55:54] == 2'h0)
      else $error("destination spare bits not zero");
   a_link_spare: assert property (destEnd && headZero == 4'h8 |-> curWord[55:52] == 4'h0)
      else $error("link identity spare bits not zero");
   a_upu_fields: assert property (upuEnd |-> headOne == 4'h1 && curWord[55:54] == 2'h0
      && curWord[63:60] == 4'h0 && curWord[59:56] inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h8})
      else $error("unavailable message fields wrong");

   cover property (shortEnd);
   cover property (destEnd);
   cover property (upuEnd);
   cover property (bitValid && !bitReady);
endmodule : snmc_link_properties

//--- dv/sig_net_mgmt_msg_codec_test.sv
// Purpose: encoder to decoder loop test plus a decoder fed by a rule-breaking driver
// Assumes: decoder buffer depth 2; consumer stalls at random and once for long
// Notes: expected messages are built from fixed code tables, never from the design
`timescale 1ns/1ps
module sig_net_mgmt_msg_codec_test;
   import snmc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reqValid = 1'b0;
   logic reqReady;
   snmc_msg_type reqData = '0;
   logic msgValid, msgReady = 1'b0, badPulse, msgValidB, badPulseB, stall = 1'b0;
   snmc_msg_type msgData, msgDataB, m, e, e2, f2;
   snmc_msg_type expQ[$], wireQ[$];
   int errors = 0, compares = 0, badA = 0, badB = 0, wn = 0, k;
   logic [63:0] wb;
   logic [31:0] lbl;
   logic [3:0] h0Tab [10] = '{4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h3, 4'h3, 4'ha};
   logic [3:0] h1Tab [10] = '{4'h3, 4'h1, 4'h2, 4'h0, 4'h1, 4'h1, 4'h0, 4'h2, 4'h1, 4'h1};
   int lenTab [10] = '{56, 56, 56, 40, 40, 56, 40, 56, 40, 64};
   logic [3:0] upTab [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8};

   always #5 clk = ~clk;
   snmc_link_if lA (.clk(clk));
   snmc_link_if lB (.clk(clk));
   snmc_encoder snmc_encoder_inst (.clk(clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
      .reqData(reqData), .link(lA));
   snmc_decoder #(.DEPTH(2)) snmc_decoder_inst (.clk(clk), .rst(rst), .link(lA), .msgValid(msgValid),
      .msgReady(msgReady), .msgData(msgData), .badPulse(badPulse));
   // second decoder faces the bench driver that sends malformed frames
   snmc_decoder #(.DEPTH(2)) snmc_decoder_inst2 (.clk(clk), .rst(rst), .link(lB), .msgValid(msgValidB),
      .msgReady(1'b0), .msgData(msgDataB), .badPulse(badPulseB));
   snmc_link_properties snmc_link_properties_inst (.clk(clk), .rst(rst), .bitValid(lA.bitValid),
      .bitData(lA.bitData), .bitLast(lA.bitLast), .bitReady(lA.bitReady));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop

   task automatic sendBits(input logic [63:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         lB.bitValid <= 1'b1;
         lB.bitData <= w[i];
         lB.bitLast <= (i == n - 1);
         do @(negedge clk); while (lB.bitReady !== 1'b1);
         @(posedge clk);
      end
      // released line shows the inverse, not a stale copy
      lB.bitValid <= 1'b0;
      lB.bitLast <= 1'b0;
      lB.bitData <= ~w[n - 1];
      @(posedge clk);
   endtask : sendBits

   // ****************************************
   // consumer, comparison and wire monitor
   // ****************************************
   always @(posedge clk) begin
      msgReady <= !rst && !stall && ($urandom % 3 != 0);
      if (badPulse === 1'b1) badA++;
      if (badPulseB === 1'b1) badB++;
   end

   always @(negedge clk) begin
      if (msgValid === 1'b1 && msgReady === 1'b1) begin
         if (expQ.size() == 0) check(64'(msgData.kind), 64'hff);
         else begin
            e2 = expQ.pop_front();
            check(64'(msgData.kind), 64'(e2.kind));
            check(64'(msgData.h1), 64'(e2.h1));
            check(64'({msgData.dpc, msgData.opc, msgData.slc}), 64'({e2.dpc, e2.opc, e2.slc}));
            if (e2.kind inside {SNMC_K_TFR, SNMC_K_RST, SNMC_K_RSR, SNMC_K_TFC, SNMC_K_UPU})
               check(64'(msgData.dest), 64'(e2.dest));
            if (e2.kind == SNMC_K_TFC) check(64'(msgData.cong), 64'(e2.cong));
            if (e2.kind == SNMC_K_DLC) check(64'(msgData.linkId), 64'(e2.linkId));
            if (e2.kind == SNMC_K_UPU) check(64'(msgData.userPart), 64'(e2.userPart));
         end
      end
      if (lA.bitValid === 1'b1 && lA.bitReady === 1'b1) begin
         wb[wn[5:0]] = lA.bitData;
         wn++;
         if (lA.bitLast === 1'b1 && wireQ.size() > 0) begin
            f2 = wireQ.pop_front();
            check(64'(wn), 64'(lenTab[f2.kind]));
            check(64'(wb[35:32]), 64'(h0Tab[f2.kind]));
            check(64'(wb[13:0]), 64'(f2.dpc));
            wn = 0;
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   initial begin
      repeat (2000) @(posedge clk);
      stall <= 1'b1;
      repeat (300) @(posedge clk);
      stall <= 1'b0;
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(27356));
      lB.bitValid = 1'b0;
      lB.bitData = 1'b0;
      lB.bitLast = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 88; i++) begin
         k = i % 11;
         m.kind = snmc_kind_type'(k);
         m.h1 = 4'($urandom);
         m.dpc = 14'($urandom);
         m.opc = 14'($urandom);
         m.slc = 4'($urandom);
         m.dest = 14'($urandom);
         m.cong = 2'($urandom);
         m.linkId = 12'($urandom);
         m.userPart = upTab[$urandom % 5];
         if (k == 3) m.h1 = 4'h1 + 4'((i / 11) % 8);
         if (k == 6) m.h1 = 4'h2 + 4'((i / 11) % 3);
         if (k < 10) begin
            e = m;
            if (k != 3 && k != 6) e.h1 = h1Tab[k];
            expQ.push_back(e);
            wireQ.push_back(e);
         end
         reqValid <= 1'b1;
         reqData <= m;
         do @(negedge clk); while (reqReady !== 1'b1);
         @(posedge clk);
         if ($urandom % 4 == 0) begin
            reqValid <= 1'b0;
            @(posedge clk);
         end
      end
      reqValid <= 1'b0;
      for (int t = 0; t < 2000 && expQ.size() != 0; t++) @(posedge clk);
      check(64'(expQ.size()), 64'h0);
      check(64'(badA), 64'h0);
      lbl = $urandom;
      sendBits({24'h0, 4'h9, 4'h6, lbl}, 40);
      sendBits({4'h0, 4'h7, 2'h0, 14'h0abc, 4'h1, 4'ha, lbl}, 64);
      sendBits({24'h0, 4'h1, 4'h7, lbl}, 56);
      repeat (3) @(posedge clk);
      check(64'(msgValidB), 64'h0);
      check(64'(badB), 64'h3);
      sendBits({24'h0, 4'h1, 4'h3, lbl}, 40);
      repeat (3) @(negedge clk);
      check(64'(msgValidB), 64'h1);
      check(64'(msgDataB.kind), 64'(SNMC_K_RCT));
      check(64'({msgDataB.slc, msgDataB.opc, msgDataB.dpc}), 64'(lbl));
      report_and_stop();
   end
endmodule : sig_net_mgmt_msg_codec_test
